/* core/sensor_irq_pkg.sv */
package sensor_irq_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_REVISION  = 8'h12;
  localparam logic [7:0] ADDR_DEVICE_ID = 8'h13;
  localparam logic [7:0] ADDR_INT_EN    = 8'h20;
  localparam logic [7:0] ADDR_PIN_SEL   = 8'h21;

  // ==========================================================================
  // Field positions (shared by enable and routing registers)
  localparam int unsigned BIT_DRDY     = 7;
  localparam int unsigned BIT_RESERVED = 6;
  localparam int unsigned BIT_BOOT     = 1;
  localparam int unsigned SRC_COUNT    = 8;

  // ==========================================================================
  // Reset values and boot image contents
  localparam logic [7:0] INT_EN_RST       = 8'h00;
  localparam logic [7:0] PIN_SEL_RST      = 8'h00;
  localparam logic [7:0] INT_EN_DEF_LOW   = 8'h00;
  localparam logic [7:0] INT_EN_DEF_HIGH  = 8'h20;
  localparam logic [7:0] PIN_SEL_DEF      = 8'h00;
  localparam logic [7:0] RDATA_RST        = 8'h00;
  localparam int unsigned OTP_WORDS       = 4;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ            = 50;
  localparam int unsigned MEAS_PHASE_X10_US  = 1261;
  localparam int unsigned MEAS_CYCLES        = (MEAS_PHASE_X10_US * CLK_MHZ + 9) / 10;
  localparam int unsigned BOOT1_PULSE_US     = 64;
  localparam int unsigned BOOT1_CYCLES       = BOOT1_PULSE_US * CLK_MHZ;
  localparam int unsigned BOOT2_PULSE_MS     = 10;
  localparam int unsigned BOOT2_CYCLES       = BOOT2_PULSE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W              = 19;
  localparam logic [CNT_W-1:0] CNT_ZERO      = 19'h00000;

  // ==========================================================================
  // Boot sequence states
  typedef enum logic [2:0] {
    ST_LOAD  = 3'b001,
    ST_PULSE = 3'b010,
    ST_RUN   = 3'b100
  } boot_state_t;

endpackage

/* core/otp_default_loader.sv */
`timescale 1ns/100ps
module otp_default_loader
  import sensor_irq_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // Strap selects the image half
  input  wire logic       strap_i,
  // Loaded defaults
  output logic            done_o,
  output logic [7:0]      int_en_o,
  output logic [7:0]      pin_sel_o
);

  // ==========================================================================
  // One-time image: enable then routing, low strap half first
  localparam logic [7:0] OTP_IMAGE [OTP_WORDS] = '{
    INT_EN_DEF_LOW, PIN_SEL_DEF, INT_EN_DEF_HIGH, PIN_SEL_DEF
  };

  logic       busy_q, busy_d;
  logic       idx_q, idx_d;
  logic       done_q, done_d;
  logic [7:0] int_en_q, int_en_d;
  logic [7:0] pin_sel_q, pin_sel_d;

  always_comb begin
    busy_d    = busy_q;
    idx_d     = idx_q;
    done_d    = 1'b0;
    int_en_d  = int_en_q;
    pin_sel_d = pin_sel_q;
    if (busy_q) begin
      idx_d = ~idx_q;
      if (!idx_q) begin
        int_en_d = OTP_IMAGE[{strap_i, idx_q}];
      end else begin
        pin_sel_d = OTP_IMAGE[{strap_i, idx_q}];
        busy_d    = 1'b0;
        done_d    = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_q    <= 1'b1;
      idx_q     <= 1'b0;
      done_q    <= 1'b0;
      int_en_q  <= INT_EN_RST;
      pin_sel_q <= PIN_SEL_RST;
    end else begin
      busy_q    <= busy_d;
      idx_q     <= idx_d;
      done_q    <= done_d;
      int_en_q  <= int_en_d;
      pin_sel_q <= pin_sel_d;
    end
  end

  assign done_o    = done_q;
  assign int_en_o  = int_en_q;
  assign pin_sel_o = pin_sel_q;

endmodule // otp_default_loader

/* core/sensor_irq_enable_routing.sv */
// Notes on behaviour
// - Data-ready interrupt is raised only while enable bit 7 is set.
// - Routing bit 7 set sends data-ready to second pin, clear to first.
// - With strap high, data-ready appears on the first pin only.
// - With strap high, second pin carries only the boot pulse.
// - Second pin in trigger-input function ignores the data-ready routing bit.
// - A measurement phase lasts 126.1 us.
// - Boot loads defaults from one-time memory, then sets boot-done.
// - Strap low: boot pulse on either pin, first pin after reset.
// - Address 13h reads a fixed identity code.
// - Address 12h reads the revision code.
// - Strap high: boot pulse on second pin only, never first.
`timescale 1ns/100ps
module sensor_irq_enable_routing
  import sensor_irq_pkg::*;
#(
  parameter int unsigned MEAS_CYCLES_P  = MEAS_CYCLES,
  parameter int unsigned BOOT2_CYCLES_P = BOOT2_CYCLES,
  // Identity values are arbitrary
  parameter logic [7:0]  DEVICE_ID_P    = 8'ha5,
  parameter logic [7:0]  REVISION_P     = 8'h5a
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // Strap and second pin function
  input  wire logic       boot_mode_strap_i,
  input  wire logic       second_pin_function_i,
  // Sensor core
  input  wire logic       sample_tick_i,
  input  wire logic [7:0] source_level_i,
  input  wire logic       data_read_i,
  // Register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Pins and status
  output logic            first_irq_pin_o,
  output logic            second_irq_pin_o,
  output logic            boot_done_o,
  output logic            measuring_o
);

  // ==========================================================================
  // Boot image loader
  logic       load_done;
  logic [7:0] otp_int_en;
  logic [7:0] otp_pin_sel;

  otp_default_loader u_loader (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .strap_i   (boot_mode_strap_i),
    .done_o    (load_done),
    .int_en_o  (otp_int_en),
    .pin_sel_o (otp_pin_sel)
  );

  // ==========================================================================
  // Boot sequence and registers
  boot_state_t      state_q, state_d;
  logic [CNT_W-1:0] pulse_cnt_q, pulse_cnt_d;
  logic             strap_q, strap_d;
  logic             boot_done_q, boot_done_d;
  logic [7:0]       int_en_q, int_en_d;
  logic [7:0]       pin_sel_q, pin_sel_d;

  always_comb begin
    state_d     = state_q;
    pulse_cnt_d = pulse_cnt_q;
    strap_d     = strap_q;
    boot_done_d = boot_done_q;
    int_en_d    = int_en_q;
    pin_sel_d   = pin_sel_q;
    unique case (state_q)
      ST_LOAD: begin
        strap_d = boot_mode_strap_i;
        if (load_done) begin
          int_en_d    = otp_int_en;
          pin_sel_d   = otp_pin_sel;
          boot_done_d = 1'b1;
          pulse_cnt_d = strap_q ? CNT_W'(BOOT2_CYCLES_P - 1) : CNT_W'(BOOT1_CYCLES - 1);
          state_d     = (strap_q || !otp_int_en[BIT_BOOT]) ? ST_PULSE : ST_RUN;
        end
      end
      ST_PULSE: begin
        if (pulse_cnt_q == CNT_ZERO) begin
          state_d = ST_RUN;
        end else begin
          pulse_cnt_d = pulse_cnt_q - CNT_W'(1);
        end
      end
      ST_RUN: begin
        pulse_cnt_d = CNT_ZERO;
      end
    endcase
    if (state_q != ST_LOAD && reg_wr_i) begin
      if (reg_addr_i == ADDR_INT_EN) begin
        int_en_d = reg_wdata_i;
      end
      if (reg_addr_i == ADDR_PIN_SEL) begin
        pin_sel_d = reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q     <= ST_LOAD;
      pulse_cnt_q <= CNT_ZERO;
      strap_q     <= 1'b0;
      boot_done_q <= 1'b0;
      int_en_q    <= INT_EN_RST;
      pin_sel_q   <= PIN_SEL_RST;
    end else begin
      state_q     <= state_d;
      pulse_cnt_q <= pulse_cnt_d;
      strap_q     <= strap_d;
      boot_done_q <= boot_done_d;
      int_en_q    <= int_en_d;
      pin_sel_q   <= pin_sel_d;
    end
  end

  // ==========================================================================
  // Measurement phase and data-ready flag
  logic [CNT_W-1:0] meas_cnt_q, meas_cnt_d;
  logic             measuring_q, measuring_d;
  logic             drdy_flag_q, drdy_flag_d;
  logic             drdy_set;

  always_comb begin
    meas_cnt_d  = meas_cnt_q;
    measuring_d = measuring_q;
    drdy_set    = 1'b0;
    if (measuring_q) begin
      if (meas_cnt_q == CNT_ZERO) begin
        measuring_d = 1'b0;
        drdy_set    = 1'b1;
      end else begin
        meas_cnt_d = meas_cnt_q - CNT_W'(1);
      end
    end else if (sample_tick_i && state_q == ST_RUN) begin
      measuring_d = 1'b1;
      meas_cnt_d  = CNT_W'(MEAS_CYCLES_P - 1);
    end
    // New sample beats a read in the same cycle
    drdy_flag_d = drdy_set | (drdy_flag_q & ~data_read_i);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meas_cnt_q  <= CNT_ZERO;
      measuring_q <= 1'b0;
      drdy_flag_q <= 1'b0;
    end else begin
      meas_cnt_q  <= meas_cnt_d;
      measuring_q <= measuring_d;
      drdy_flag_q <= drdy_flag_d;
    end
  end

  // ==========================================================================
  // Source gating and pin routing
  logic [SRC_COUNT-1:0] src_hit;
  logic [SRC_COUNT-1:0] to_second;
  logic                 boot_on;
  logic                 boot_to_second;
  logic                 first_pin_d, second_pin_d;
  logic                 first_pin_q, second_pin_q;

  for (genvar i = 0; i < SRC_COUNT; i++) begin : g_src
    if (i == BIT_DRDY) begin : g_drdy
      assign src_hit[i]   = int_en_q[i] & drdy_flag_q & (state_q != ST_LOAD);
      assign to_second[i] = pin_sel_q[i] & ~strap_q & ~second_pin_function_i;
    end else if (i == BIT_BOOT) begin : g_boot
      assign src_hit[i]   = 1'b0;
      assign to_second[i] = 1'b0;
    end else if (i == BIT_RESERVED) begin : g_nosel
      assign src_hit[i]   = int_en_q[i] & source_level_i[i] & (state_q != ST_LOAD);
      assign to_second[i] = 1'b0;
    end else begin : g_other
      assign src_hit[i]   = int_en_q[i] & source_level_i[i] & (state_q != ST_LOAD);
      assign to_second[i] = pin_sel_q[i] & ~strap_q;
    end
  end

  assign boot_on        = (state_q == ST_PULSE);
  assign boot_to_second = strap_q | pin_sel_q[BIT_BOOT];

  always_comb begin
    first_pin_d  = |(src_hit & ~to_second) | (boot_on & ~boot_to_second);
    second_pin_d = |(src_hit & to_second) | (boot_on & boot_to_second);
  end

  // ==========================================================================
  // Register read port
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_REVISION:  rdata_d = REVISION_P;
        ADDR_DEVICE_ID: rdata_d = DEVICE_ID_P;
        ADDR_INT_EN:    rdata_d = int_en_q;
        ADDR_PIN_SEL:   rdata_d = pin_sel_q;
        default:        rdata_d = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      first_pin_q  <= 1'b0;
      second_pin_q <= 1'b0;
      rdata_q      <= RDATA_RST;
    end else begin
      first_pin_q  <= first_pin_d;
      second_pin_q <= second_pin_d;
      rdata_q      <= rdata_d;
    end
  end

  assign first_irq_pin_o  = first_pin_q;
  assign second_irq_pin_o = second_pin_q;
  assign reg_rdata_o      = rdata_q;
  assign boot_done_o      = boot_done_q;
  assign measuring_o      = measuring_q;

  // ==========================================================================
  // Checks
  int unsigned meas_len_q;

  always_ff @(posedge clock_i) begin
    if (srst_i || !measuring_o) begin
      meas_len_q <= 0;
    end else begin
      meas_len_q <= meas_len_q + 1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_drdy_gated;
    (state_q == ST_RUN && drdy_flag_q && !int_en_q[BIT_DRDY] && source_level_i == 8'h00)
      |=> (!first_irq_pin_o && !second_irq_pin_o);
  endproperty
  a_drdy_gated: assert property (p_drdy_gated) else $error("drdy seen while disabled");

  property p_drdy_second;
    (state_q == ST_RUN && drdy_flag_q && int_en_q[BIT_DRDY] && pin_sel_q[BIT_DRDY]
      && !strap_q && !second_pin_function_i) |=> second_irq_pin_o;
  endproperty
  a_drdy_second: assert property (p_drdy_second) else $error("drdy not on second pin");

  property p_strap_first;
    (state_q == ST_RUN && strap_q && drdy_flag_q && int_en_q[BIT_DRDY])
      |=> first_irq_pin_o;
  endproperty
  a_strap_first: assert property (p_strap_first) else $error("drdy lost in strap high");

  property p_strap_quiet;
    (state_q == ST_RUN && strap_q) |=> !second_irq_pin_o;
  endproperty
  a_strap_quiet: assert property (p_strap_quiet) else $error("second pin used in strap high");

  property p_trigger_ignores;
    (state_q == ST_RUN && second_pin_function_i && drdy_flag_q && int_en_q[BIT_DRDY]
      && source_level_i == 8'h00) |=> (first_irq_pin_o && !second_irq_pin_o);
  endproperty
  a_trigger_ignores: assert property (p_trigger_ignores) else $error("routing not ignored");

  property p_meas_len;
    $fell(measuring_o) |-> (meas_len_q == MEAS_CYCLES_P && drdy_flag_q);
  endproperty
  a_meas_len: assert property (p_meas_len) else $error("measurement phase length wrong");

  property p_boot_done;
    (state_q == ST_LOAD && load_done) |=> (boot_done_o && state_q != ST_LOAD);
  endproperty
  a_boot_done: assert property (p_boot_done) else $error("boot done not set");

  property p_boot_first;
    $rose(state_q == ST_PULSE) && !strap_q && !pin_sel_q[BIT_BOOT] && source_level_i == 8'h00
      |=> (first_irq_pin_o && !second_irq_pin_o);
  endproperty
  a_boot_first: assert property (p_boot_first) else $error("boot pulse not on first pin");

  property p_boot_second;
    (state_q == ST_PULSE && strap_q && source_level_i == 8'h00)
      |=> (second_irq_pin_o && !first_irq_pin_o);
  endproperty
  a_boot_second: assert property (p_boot_second) else $error("strap high boot pulse wrong");

  property p_read_id;
    (reg_rd_i && reg_addr_i == ADDR_DEVICE_ID) |=> (reg_rdata_o == DEVICE_ID_P);
  endproperty
  a_read_id: assert property (p_read_id) else $error("identity read wrong");

  property p_read_rev;
    (reg_rd_i && reg_addr_i == ADDR_REVISION) |=> (reg_rdata_o == REVISION_P);
  endproperty
  a_read_rev: assert property (p_read_rev) else $error("revision read wrong");

  c_boot_high: cover property (state_q == ST_PULSE && strap_q);
  c_drdy_second: cover property (second_irq_pin_o && drdy_flag_q);
  c_meas_done: cover property ($fell(measuring_o));

endmodule // sensor_irq_enable_routing

/* tb/host_irq_model.sv */
`timescale 1ns/100ps
module host_irq_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // Bench control
  input  wire logic       arm_i,
  input  wire logic [7:0] delay_i,
  // Device pins
  input  wire logic       first_irq_pin_i,
  input  wire logic       second_irq_pin_i,
  input  wire logic       measuring_i,
  // Host actions
  output logic            data_read_o,
  output logic            late_o
);
  logic       pin_q;
  logic       busy_q;
  logic [7:0] wait_q;

  // ==========================================================================
  // Burst read after each rising edge on either pin, while armed and idle
  always_ff @(posedge clock_i) begin
    data_read_o <= 1'b0;
    pin_q       <= first_irq_pin_i | second_irq_pin_i;
    if (srst_i) begin
      busy_q <= 1'b0;
      wait_q <= 8'h00;
      late_o <= 1'b0;
    end else if (busy_q) begin
      if (measuring_i) begin
        late_o <= 1'b1;
      end
      if (wait_q == 8'h00) begin
        data_read_o <= 1'b1;
        busy_q      <= 1'b0;
      end else begin
        wait_q <= wait_q - 8'h01;
      end
    end else if (arm_i && !pin_q && (first_irq_pin_i | second_irq_pin_i)) begin
      busy_q <= 1'b1;
      wait_q <= delay_i;
    end
  end
endmodule // host_irq_model

/* tb/sensor_irq_enable_routing_tb.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module sensor_irq_enable_routing_tb;
  import sensor_irq_pkg::*;
  localparam int MEAS_N = 20;
  localparam int BOOT2_N = 40;
  // Identity values are arbitrary
  localparam logic [7:0] ID_V  = 8'h3c;
  localparam logic [7:0] REV_V = 8'hc3;
  logic       clock_i, srst_i, strap, func, tick, rd, wr, arm, dread, late;
  logic       p1, p2, done, meas;
  logic [7:0] src, addr, wdata, rdata, dly;
  int         err_count, compares, cycles, n1, n2, k;

  sensor_irq_enable_routing #(.MEAS_CYCLES_P(MEAS_N), .BOOT2_CYCLES_P(BOOT2_N),
    .DEVICE_ID_P(ID_V), .REVISION_P(REV_V)) dut_u (
    .clock_i(clock_i), .srst_i(srst_i), .boot_mode_strap_i(strap),
    .second_pin_function_i(func), .sample_tick_i(tick), .source_level_i(src),
    .data_read_i(dread), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .first_irq_pin_o(p1),
    .second_irq_pin_o(p2), .boot_done_o(done), .measuring_o(meas));

  host_irq_model host_u (
    .clock_i(clock_i), .srst_i(srst_i), .arm_i(arm), .delay_i(dly),
    .first_irq_pin_i(p1), .second_irq_pin_i(p2), .measuring_i(meas),
    .data_read_o(dread), .late_o(late));

  // ==========================================================================
  // Clock, timeout, verdict
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Access tasks
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clock_i);
    rd <= 1'b1; addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    `CHK(nm, exp, rdata)
  endtask

  task automatic do_reset(input logic s);
    @(posedge clock_i);
    srst_i <= 1'b1; strap <= s;
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    k = 0;
    step(1);
    while (done !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    `CHK("boot_done", 1'b1, done)
  endtask

  // Length of the boot pulse on each pin
  task automatic boot_pulse();
    n1 = 0; n2 = 0; k = 0;
    while (!(p1 | p2) && k < 20) begin
      step(1);
      k++;
    end
    while ((p1 | p2) && k < 5000) begin
      n1 += int'(p1); n2 += int'(p2);
      step(1);
      k++;
    end
  endtask

  // One measurement, then the expected pins
  task automatic drdy(input logic e1, input logic e2, input string nm);
    @(posedge clock_i);
    tick <= 1'b1;
    @(posedge clock_i);
    tick <= 1'b0;
    k = 0;
    #1;
    while (!meas && k < 5) begin
      step(1);
      k++;
    end
    n1 = 0;
    while (meas && n1 < 200) begin
      n1++;
      step(1);
    end
    `CHK("meas_len", MEAS_N, n1)
    step(1);
    `CHK({nm, "_p1"}, e1, p1)
    `CHK({nm, "_p2"}, e2, p2)
    k = 0;
    while (arm && (p1 | p2) && k < 60) begin
      step(1);
      k++;
    end
    `CHK({nm, "_clr"}, 2'b00, {p1, p2})
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    srst_i = 1'b1; strap = 1'b0; func = 1'b0; tick = 1'b0; src = 8'h00;
    rd = 1'b0; wr = 1'b0; addr = 8'h00; wdata = 8'h00; arm = 1'b1; dly = 8'h02;
    do_reset(1'b0);
    boot_pulse();
    `CHK("boot1_first", BOOT1_CYCLES, n1)
    `CHK("boot1_second", 0, n2)
    $display("Test boot low done");
    reg_wr(ADDR_REVISION, 8'h00);
    reg_chk(ADDR_REVISION, REV_V, "revision");
    reg_chk(ADDR_DEVICE_ID, ID_V, "identity");
    reg_chk(ADDR_INT_EN, INT_EN_DEF_LOW, "int_en_rst");
    reg_chk(ADDR_PIN_SEL, PIN_SEL_DEF, "pin_sel_rst");
    reg_chk(8'h30, 8'h00, "unmapped");
    $display("Test registers done");
    reg_wr(ADDR_INT_EN, 8'h80);
    reg_chk(ADDR_INT_EN, 8'h80, "int_en_wr");
    drdy(1'b1, 1'b0, "drdy_first");
    dly = 8'h1e;
    reg_wr(ADDR_PIN_SEL, 8'h80);
    drdy(1'b0, 1'b1, "drdy_second");
    @(posedge clock_i);
    func <= 1'b1;
    drdy(1'b1, 1'b0, "drdy_trigger");
    `CHK("host_late_low", 1'b0, late)
    arm = 1'b0;
    @(posedge clock_i);
    func <= 1'b0;
    $display("Test data ready done");
    reg_wr(ADDR_INT_EN, 8'h88);
    reg_wr(ADDR_PIN_SEL, 8'h08);
    @(posedge clock_i);
    src <= 8'h08;
    step(3);
    `CHK("src_second", 2'b01, {p1, p2})
    reg_wr(ADDR_PIN_SEL, 8'h00);
    step(3);
    `CHK("src_first", 2'b10, {p1, p2})
    reg_wr(ADDR_INT_EN, 8'h40);
    reg_wr(ADDR_PIN_SEL, 8'h40);
    @(posedge clock_i);
    src <= 8'h40;
    step(3);
    `CHK("src_fixed", 2'b10, {p1, p2})
    @(posedge clock_i);
    src <= 8'h00;
    reg_wr(ADDR_INT_EN, 8'h00);
    drdy(1'b0, 1'b0, "drdy_off");
    $display("Test routing done");
    do_reset(1'b1);
    boot_pulse();
    `CHK("boot2_first", 0, n1)
    `CHK("boot2_second", BOOT2_N, n2)
    reg_chk(ADDR_INT_EN, INT_EN_DEF_HIGH, "int_en_high");
    arm = 1'b1;
    reg_wr(ADDR_INT_EN, 8'h80);
    reg_wr(ADDR_PIN_SEL, 8'h80);
    drdy(1'b1, 1'b0, "drdy_strap");
    `CHK("host_late", 1'b0, late)
    $display("Test boot high done");
    print_verdict();
  end
endmodule // sensor_irq_enable_routing_tb
